// ===== rtl/ccp_pkg.sv
package ccp_pkg;

  // ----------------------------------------------------------------
  // Register space
  // ----------------------------------------------------------------
  localparam int CCP_NUM_REGS = 32;
  localparam int CCP_ADDR_W = 5;
  localparam logic [7:0] CCP_REG_RST = 8'h00;
  localparam logic [4:0] CCP_STATUS_ADDR = 5'h1f;

  // ----------------------------------------------------------------
  // Pointer byte layout and reset value
  // ----------------------------------------------------------------
  localparam logic [7:0] CCP_PTR_RST = 8'h81;
  localparam logic [7:0] CCP_PTR_MASK = 8'h9f;
  localparam int CCP_PTR_INC_BIT = 7;

  // ----------------------------------------------------------------
  // Chip addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] CCP_SPI_CHIP_ADDR = 7'h10;
  localparam logic [5:0] CCP_I2C_ADDR_HI = 6'h08;

  // ----------------------------------------------------------------
  // Bit counter positions
  // ----------------------------------------------------------------
  localparam logic [3:0] CCP_CNT_ZERO = 4'h0;
  localparam logic [3:0] CCP_CNT_FIRST = 4'h1;
  localparam logic [3:0] CCP_CNT_LAST = 4'h7;
  localparam logic [3:0] CCP_CNT_ACK = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCP_ST_IDLE,
    CCP_ST_ADDR,
    CCP_ST_PTR,
    CCP_ST_WDATA,
    CCP_ST_RDATA,
    CCP_ST_SKIP
  } ccp_state_e;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } ccp_wr_s;

endpackage : ccp_pkg

// ===== rtl/ccp_control_port.sv
// Function
// - Strap level on audio output pin at reset release picks SPI (high) or I2C.
// - Port is slave only; never drives the bit clock or starts transfers.
// - SPI mode is write only; no read-back path exists.
// - SPI data bits captured on rising edge of the bit clock.
// - Seven-bit chip address 0010000 comes first; mismatch ignores the transfer.
// - SPI byte after direction bit loads the register pointer.
// - Each data byte after the pointer lands in the pointed register.
// - Auto-increment clear: pointer holds across successive data bytes.
// - Auto-increment set: pointer advances by one after every byte read or written.
// - I2C address is 001000 plus the address-select pin as LSB.
// - Respond only when address LSB after Start matches address-select pin.
// - I2C eighth address bit high requests read, low requests write.
// - First byte of an I2C write loads the register pointer.
// - I2C read shifts out the register selected by the pointer.
// - Every I2C byte is followed by an acknowledge from the receiver.
// - All registers read/write except the status register, which ignores writes.
// - Port works with its bit clock asynchronous to the system clock.
// - Pointer: auto-increment in bit 7, address in bits 4..0, auto-increment set after reset.
// - Reset low restores defaults and keeps the port inactive.
`timescale 1ns/1ps
module ccp_control_port #(
  parameter int NUM_REGS = ccp_pkg::CCP_NUM_REGS,
  parameter logic [4:0] STATUS_ADDR = ccp_pkg::CCP_STATUS_ADDR
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ctrl_bit_clock_in,
  input wire logic select_b_in,
  input wire logic ctrl_serial_in,
  input wire logic addr_select_pin_in,
  input wire logic audio_serial_out_in,
  input wire logic [7:0] status_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  output logic mode_spi_out,
  output logic [NUM_REGS*8-1:0] cfg_regs_out
);
  import ccp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic mode_strap_r;
  logic frame_rst_b;
  logic start_tog_r;
  logic start_ack_r;
  logic start_pend;
  logic begin_frame;
  ccp_state_e st_r;
  logic [3:0] cnt_r;
  logic [6:0] shift_r;
  logic [7:0] byte_in;
  logic ack_r;
  logic rd_skip_r;
  logic byte_done;
  logic addr_match;
  logic load_ptr;
  logic wr_now;
  logic rd_done;
  logic [7:0] ptr_r;
  logic [4:0] ptr_addr;
  logic [7:0] regs_link [NUM_REGS];
  logic [7:0] rd_byte;
  logic rd_bit;
  logic drive_r;
  logic adsel_meta_r;
  logic adsel_r;
  logic [7:0] stat_meta_r;
  logic [7:0] stat_r;
  ccp_wr_s wr_hold_r;
  logic wr_tog_r;
  logic [2:0] wr_sync_r;
  logic wr_evt;
  logic mode_meta_r;
  logic mode_sync_r;
  logic [7:0] regs_sys [NUM_REGS];

  // ----------------------------------------------------------------
  // Interface selection strap
  // ----------------------------------------------------------------

  // Pin level caught on the reset release edge, static afterwards
  always_ff @(posedge rst_b_in) begin
    mode_strap_r <= audio_serial_out_in;
  end

  // SPI select high clears the frame logic; I2C uses only the reset
  assign frame_rst_b = rst_b_in & ~(mode_strap_r & select_b_in);

  // ----------------------------------------------------------------
  // Start condition capture
  // ----------------------------------------------------------------

  // Data falling while the bit clock is high flips the start toggle
  always_ff @(negedge ctrl_serial_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      start_tog_r <= 1'b0;
    end else if (ctrl_bit_clock_in) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  // A fresh frame starts at the first rising edge after start or select
  assign start_pend = start_tog_r ^ start_ack_r;
  assign begin_frame = mode_strap_r ? (st_r == CCP_ST_IDLE) : start_pend;

  // ----------------------------------------------------------------
  // Link side input synchronisers
  // ----------------------------------------------------------------

  // Address-select pin and status bits are levels from outside
  always_ff @(posedge ctrl_bit_clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      adsel_meta_r <= 1'b0;
      adsel_r <= 1'b0;
      stat_meta_r <= 8'h00;
      stat_r <= 8'h00;
    end else begin
      adsel_meta_r <= addr_select_pin_in;
      adsel_r <= adsel_meta_r;
      stat_meta_r <= status_in;
      stat_r <= stat_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------

  // Incoming byte once the current bit is shifted in
  assign byte_in = {shift_r, ctrl_serial_in};

  // Chip address compare for the active interface
  always_comb begin
    if (mode_strap_r) begin
      addr_match = (byte_in[7:1] == CCP_SPI_CHIP_ADDR) && !byte_in[0];
    end else begin
      addr_match = (byte_in[7:1] == {CCP_I2C_ADDR_HI, adsel_r});
    end
  end

  // Completion strobes for the pointer and register updates
  assign byte_done = !begin_frame && (cnt_r == CCP_CNT_LAST) &&
    ((st_r == CCP_ST_ADDR) || (st_r == CCP_ST_PTR) || (st_r == CCP_ST_WDATA));
  assign load_ptr = byte_done && (st_r == CCP_ST_PTR);
  assign wr_now = byte_done && (st_r == CCP_ST_WDATA);
  // The acknowledge of the address byte is not a byte read, so it must not move the pointer
  assign rd_done = !begin_frame && (st_r == CCP_ST_RDATA) && (cnt_r == CCP_CNT_ACK) && !rd_skip_r;

  // ----------------------------------------------------------------
  // Link state machine (rising edge of the bit clock)
  // ----------------------------------------------------------------

  // Sample data on the rising edge, count bits, step through phases
  always_ff @(posedge ctrl_bit_clock_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      st_r <= CCP_ST_IDLE;
      cnt_r <= CCP_CNT_ZERO;
      shift_r <= 7'h00;
      ack_r <= 1'b0;
      rd_skip_r <= 1'b0;
      start_ack_r <= 1'b0;
    end else begin
      ack_r <= 1'b0;
      rd_skip_r <= 1'b0;
      if (begin_frame) begin
        st_r <= CCP_ST_ADDR;
        cnt_r <= CCP_CNT_FIRST;
        shift_r <= {6'h00, ctrl_serial_in};
        start_ack_r <= start_tog_r;
      end else begin
        case (st_r)
          CCP_ST_ADDR, CCP_ST_PTR, CCP_ST_WDATA: begin
            if (cnt_r == CCP_CNT_ACK) begin
              cnt_r <= CCP_CNT_ZERO;
            end else if (cnt_r == CCP_CNT_LAST) begin
              cnt_r <= mode_strap_r ? CCP_CNT_ZERO : CCP_CNT_ACK;
              if (st_r == CCP_ST_ADDR) begin
                if (!addr_match) begin
                  st_r <= CCP_ST_SKIP;
                end else if (!mode_strap_r && byte_in[0]) begin
                  st_r <= CCP_ST_RDATA;
                  ack_r <= 1'b1;
                  rd_skip_r <= 1'b1;
                end else begin
                  st_r <= CCP_ST_PTR;
                  ack_r <= !mode_strap_r;
                end
              end else begin
                st_r <= CCP_ST_WDATA;
                ack_r <= !mode_strap_r;
              end
            end else begin
              shift_r <= byte_in[6:0];
              cnt_r <= cnt_r + CCP_CNT_FIRST;
            end
          end
          CCP_ST_RDATA: begin
            if (cnt_r == CCP_CNT_ACK) begin
              cnt_r <= CCP_CNT_ZERO;
              if (ctrl_serial_in) begin
                st_r <= CCP_ST_IDLE;
              end
            end else begin
              cnt_r <= cnt_r + CCP_CNT_FIRST;
            end
          end
          default: begin
            cnt_r <= cnt_r;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register pointer
  // ----------------------------------------------------------------

  // Pointer survives frames; only reset restores its default
  always_ff @(posedge ctrl_bit_clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_r <= CCP_PTR_RST;
    end else if (load_ptr) begin
      ptr_r <= byte_in & CCP_PTR_MASK;
    end else if ((wr_now || rd_done) && ptr_r[CCP_PTR_INC_BIT]) begin
      ptr_r <= {ptr_r[7:5], ptr_r[4:0] + 5'h01};
    end
  end

  // Without auto-increment the pointer simply keeps its value
  assign ptr_addr = ptr_r[4:0];

  // ----------------------------------------------------------------
  // Link side register copy
  // ----------------------------------------------------------------

  // Mirror of the configuration written by this port, used for reads
  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_link_reg
      always_ff @(posedge ctrl_bit_clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          regs_link[i] <= CCP_REG_RST;
        end else if (wr_now && (ptr_addr == 5'(i)) && (ptr_addr != STATUS_ADDR)) begin
          regs_link[i] <= byte_in;
        end
      end
    end
  endgenerate

  // Read data: status comes live from the core, the rest from the copy
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_addr == STATUS_ADDR) begin
      rd_byte = stat_r;
    end else if (32'(ptr_addr) < NUM_REGS) begin
      rd_byte = regs_link[ptr_addr];
    end
  end

  assign rd_bit = rd_byte[3'h7 - cnt_r[2:0]];

  // ----------------------------------------------------------------
  // Data line drive (falling edge of the bit clock)
  // ----------------------------------------------------------------

  // Open-drain pull low for acknowledge or a zero read bit, I2C only
  always_ff @(negedge ctrl_bit_clock_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= !mode_strap_r && (ack_r ||
        ((st_r == CCP_ST_RDATA) && (cnt_r != CCP_CNT_ACK) && !rd_bit));
    end
  end

  // Only ever pulls low; the bit clock is never an output
  assign sda_out = 1'b0;
  assign sda_oe_b_out = ~drive_r;

  // ----------------------------------------------------------------
  // Write hand-off to the system domain
  // ----------------------------------------------------------------

  // Word held stable while a toggle announces it
  always_ff @(posedge ctrl_bit_clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_hold_r <= '0;
      wr_tog_r <= 1'b0;
    end else if (wr_now && (ptr_addr != STATUS_ADDR)) begin
      wr_hold_r.addr <= ptr_addr;
      wr_hold_r.data <= byte_in;
      wr_tog_r <= ~wr_tog_r;
    end
  end

  // Toggle synchroniser plus edge stage
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_sync_r <= 3'h0;
    end else begin
      wr_sync_r <= {wr_sync_r[1:0], wr_tog_r};
    end
  end

  assign wr_evt = wr_sync_r[2] ^ wr_sync_r[1];

  // ----------------------------------------------------------------
  // System side registers
  // ----------------------------------------------------------------

  // Configuration as seen by the rest of the chip
  generate
    for (genvar j = 0; j < NUM_REGS; j++) begin : g_sys_reg
      always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          regs_sys[j] <= CCP_REG_RST;
        end else if (wr_evt && (wr_hold_r.addr == 5'(j))) begin
          regs_sys[j] <= wr_hold_r.data;
        end
      end
      assign cfg_regs_out[j*8 +: 8] = regs_sys[j];
    end
  endgenerate

  // Selected interface reported in the system domain
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_meta_r <= 1'b0;
      mode_sync_r <= 1'b0;
    end else begin
      mode_meta_r <= mode_strap_r;
      mode_sync_r <= mode_meta_r;
    end
  end

  assign mode_spi_out = mode_sync_r;

endmodule : ccp_control_port

// ===== test/ccp_chk.sv
`timescale 1ns/1ps
// ----------------
// Port checker
// ----------------
module ccp_chk #(
  parameter int NUM_REGS = 32,
  parameter logic [4:0] STATUS_ADDR = 5'h1f
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ctrl_bit_clock_in,
  input wire logic select_b_in,
  input wire logic ctrl_serial_in,
  input wire logic addr_select_pin_in,
  input wire logic audio_serial_out_in,
  input wire logic [7:0] status_in,
  input wire logic sda_out,
  input wire logic sda_oe_b_out,
  input wire logic mode_spi_out,
  input wire logic [NUM_REGS*8-1:0] cfg_regs_out
);
  logic [3:0] low_cnt_r;

  // Length of the current run of the port pulling the data line low
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      low_cnt_r <= 4'h0;
    end else if (sda_oe_b_out) begin
      low_cnt_r <= 4'h0;
    end else if (low_cnt_r != 4'hf) begin
      low_cnt_r <= low_cnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  // Reset, mode, register and data line behaviour
  chk_reset_quiet: assert property (@(posedge clk_sys_in) disable iff (1'b0)
    !rst_b_in |-> (cfg_regs_out == '0) && sda_oe_b_out && !mode_spi_out) else $error("port busy in reset");
  chk_strap_mode: assert property ($rose(rst_b_in) ##2 1'b1 |-> mode_spi_out == audio_serial_out_in)
    else $error("mode differs from strap");
  chk_mode_hold: assert property (rst_b_in && $past(rst_b_in, 3) |-> $stable(mode_spi_out))
    else $error("mode changed while running");
  chk_spi_silent: assert property (mode_spi_out |-> sda_oe_b_out)
    else $error("data line driven in spi mode");
  chk_status_kept: assert property (cfg_regs_out[STATUS_ADDR*8 +: 8] == 8'h00)
    else $error("status slot was written");
  chk_sel_quiet: assert property ((mode_spi_out && select_b_in) [*8] |=> $stable(cfg_regs_out))
    else $error("register write while deselected");
  chk_one_write: assert property ($changed(cfg_regs_out) |=> $stable(cfg_regs_out) [*2])
    else $error("registers changed too fast");
  chk_ack_bound: assert property (low_cnt_r <= 4'h8)
    else $error("data line held low too long");
  chk_data_const: assert property (sda_out == 1'b0)
    else $error("open drain value not low");

  // Main scenarios
  cov_spi_write: cover property (mode_spi_out && $changed(cfg_regs_out));
  cov_i2c_ack: cover property (!mode_spi_out && !sda_oe_b_out);
  cov_reset_rel: cover property ($rose(rst_b_in));
endmodule : ccp_chk

bind ccp_control_port ccp_chk #(.NUM_REGS(NUM_REGS), .STATUS_ADDR(STATUS_ADDR)) u_chk (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ctrl_bit_clock_in(ctrl_bit_clock_in),
  .select_b_in(select_b_in), .ctrl_serial_in(ctrl_serial_in), .addr_select_pin_in(addr_select_pin_in),
  .audio_serial_out_in(audio_serial_out_in), .status_in(status_in), .sda_out(sda_out),
  .sda_oe_b_out(sda_oe_b_out), .mode_spi_out(mode_spi_out), .cfg_regs_out(cfg_regs_out)
);

// ===== test/ccp_host_model.sv
`timescale 1ns/1ps
// ----------------
// Host master model; bit clock runs only inside transfers
// ----------------
module ccp_host_model (
  output logic bclk_out,
  output logic sel_b_out,
  output logic dat_out,
  input wire logic sda_in
);
  // Idle levels
  initial begin
    bclk_out = 1'b0;
    sel_b_out = 1'b1;
    dat_out = 1'b1;
  end

  // Select line, held static between frames
  task automatic select(input logic b);
    #2 sel_b_out = b;
    #5;
  endtask : select

  // One bit, 15 ns: data moves while the clock is low, taken at the rise
  task automatic bit_io(input logic b, output logic s);
    #2 dat_out = b;
    #5.5 bclk_out = 1'b1;
    s = sda_in;
    #7.5 bclk_out = 1'b0;
  endtask : bit_io

  // One byte, most significant bit first
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
  endtask : byte_io

  // Start: data falls while the clock is high
  task automatic i2c_start();
    #2 dat_out = 1'b1;
    #3 bclk_out = 1'b1;
    #5 dat_out = 1'b0;
    #5 bclk_out = 1'b0;
  endtask : i2c_start

  // Stop: data rises while the clock is high
  task automatic i2c_stop();
    #2 dat_out = 1'b0;
    #3 bclk_out = 1'b1;
    #5 dat_out = 1'b1;
  endtask : i2c_stop
endmodule : ccp_host_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  import ccp_pkg::*;
  logic clk_sys, rst_b, strap, ad_pin, ack;
  logic [7:0] status, rx;
  logic bclk, sel_b, dat, sda_w, sda, oe_b, mode;
  logic [CCP_NUM_REGS*8-1:0] regs;
  int n_errors = 0;
  int n_checks = 0;

  // Open-drain data wire with pull-up
  assign sda_w = dat & (oe_b | sda);

  ccp_host_model host (.bclk_out(bclk), .sel_b_out(sel_b), .dat_out(dat), .sda_in(sda_w));
  ccp_control_port dut (
    .clk_sys_in(clk_sys), .rst_b_in(rst_b), .ctrl_bit_clock_in(bclk), .select_b_in(sel_b),
    .ctrl_serial_in(sda_w), .addr_select_pin_in(ad_pin), .audio_serial_out_in(strap),
    .status_in(status), .sda_out(sda), .sda_oe_b_out(oe_b), .mode_spi_out(mode), .cfg_regs_out(regs)
  );

  // System clock, 50 MHz
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] rg(input int a);
    return regs[a*8 +: 8];
  endfunction : rg

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic do_reset(input logic s);
    @(posedge clk_sys) rst_b <= 1'b0;
    strap <= s;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset

  task automatic spi_frame(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
    host.select(1'b0);
    host.byte_io(a, rx);
    host.byte_io(p, rx);
    host.byte_io(d0, rx);
    host.byte_io(d1, rx);
    host.select(1'b1);
    repeat (6) @(posedge clk_sys);
  endtask : spi_frame

  // Byte out, then the acknowledge slot; exp is the expected line level there
  task automatic i2c_send(input logic [7:0] b, input logic exp);
    host.byte_io(b, rx);
    host.bit_io(1'b1, ack);
    check("ack slot", {7'h0, exp}, {7'h0, ack});
  endtask : i2c_send

  task automatic i2c_recv(input logic [7:0] exp, input logic last);
    host.byte_io(8'hff, rx);
    host.bit_io(last, ack);
    check("read data", exp, rx);
  endtask : i2c_recv

  task automatic t_spi();
    check("spi mode", 8'h01, {7'h0, mode});
    spi_frame(8'h20, 8'h82, 8'h5a, 8'ha5);
    check("reg2", 8'h5a, rg(2));
    check("reg3", 8'ha5, rg(3));
    spi_frame(8'h20, 8'h05, 8'h11, 8'h22);
    check("reg5", 8'h22, rg(5));
    check("reg6", 8'h00, rg(6));
    spi_frame(8'h22, 8'h07, 8'h33, 8'h44);
    spi_frame(8'h21, 8'h07, 8'h33, 8'h44);
    check("reg7", 8'h00, rg(7));
    spi_frame(8'h20, 8'h9e, 8'h66, 8'h77);
    check("reg30", 8'h66, rg(30));
    check("reg31", 8'h00, rg(31));
    host.select(1'b0);
    repeat (4) host.bit_io(1'b1, ack);
    host.select(1'b1);
    spi_frame(8'h20, 8'h88, 8'h99, 8'haa);
    check("reg8", 8'h99, rg(8));
    check("reg9", 8'haa, rg(9));
    check("spi drive", 8'h01, {7'h0, oe_b});
    $display("test spi done");
  endtask : t_spi

  task automatic t_i2c();
    check("i2c mode", 8'h00, {7'h0, mode});
    check("reg2 cleared", 8'h00, rg(2));
    host.i2c_start();
    i2c_send(8'h20, 1'b1);
    host.i2c_stop();
    @(posedge clk_sys) ad_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    host.i2c_start();
    i2c_send(8'h20, 1'b0);
    i2c_send(8'h83, 1'b0);
    i2c_send(8'h11, 1'b0);
    i2c_send(8'h12, 1'b0);
    host.i2c_stop();
    repeat (6) @(posedge clk_sys);
    check("reg3", 8'h11, rg(3));
    check("reg4", 8'h12, rg(4));
    host.i2c_start();
    i2c_send(8'h20, 1'b0);
    i2c_send(8'h03, 1'b0);
    host.i2c_start();
    i2c_send(8'h21, 1'b0);
    i2c_recv(8'h11, 1'b0);
    i2c_recv(8'h11, 1'b1);
    host.i2c_stop();
    host.i2c_start();
    i2c_send(8'h21, 1'b0);
    i2c_recv(8'h11, 1'b1);
    host.i2c_start();
    i2c_send(8'h20, 1'b0);
    i2c_send(8'h83, 1'b0);
    host.i2c_start();
    i2c_send(8'h21, 1'b0);
    i2c_recv(8'h11, 1'b0);
    i2c_recv(8'h12, 1'b1);
    host.i2c_start();
    i2c_send(8'h20, 1'b0);
    i2c_send(8'h1f, 1'b0);
    i2c_send(8'h77, 1'b0);
    host.i2c_start();
    i2c_send(8'h21, 1'b0);
    i2c_recv(8'h5c, 1'b1);
    host.i2c_stop();
    repeat (6) @(posedge clk_sys);
    check("reg31", 8'h00, rg(31));
    $display("test i2c done");
  endtask : t_i2c

  // Main sequence
  initial begin
    rst_b = 1'b0;
    strap = 1'b1;
    ad_pin = 1'b1;
    status = 8'h5c;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_spi();
    do_reset(1'b0);
    t_i2c();
    end_sim();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("[ERR] run length expected end seen timeout");
    end_sim();
  end
endmodule : tb
